// ### bench/gpio_capture_asserts.sv
// Bus timing and interrupt checks for the capture block
module gpio_capture_asserts
   import capture_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_PINS-1:0] gpio_in,
   input wire ptc_time_t ptc_now,
   input wire logic irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic in_smp = paddr >= OFS_SAMPLE_BASE && paddr < OFS_SAMPLE_END;
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   property p_one_wait;
      s_setup |-> !pready ##1 pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   property p_ready_access;
      pready |-> psel && penable;
   endproperty
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_part_gap;
      pready && in_smp && paddr[3:2] == 2'h3 |-> pslverr;
   endproperty
   a_part_gap: assert property (p_part_gap) else $error("gap slot not refused");
   property p_fraction;
      pready && !pwrite && in_smp && paddr[3:2] == PART_FRACTION |-> prdata <= 32'h4;
   endproperty
   a_fraction: assert property (p_fraction) else $error("fraction out of range");
   property p_irq_rise;
      $rose(irq) |-> ($past(pready) && $past(pwrite)) || $past(gpio_in, 3) != $past(gpio_in, 4)
         || $past(gpio_in, 4) != $past(gpio_in, 5);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
   property p_irq_fall;
      $fell(irq) |-> $past(pready) && $past(pwrite);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule : gpio_capture_asserts
bind gpio_capture gpio_capture_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .gpio_in, .ptc_now, .irq);

// ### bench/pin_source.sv
// Far-side model: GPIO signal levels and a free-running precision time
module pin_source
   import capture_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NUM_PINS-1:0] level_req,
   output logic [NUM_PINS-1:0] gpio_in,
   output ptc_time_t ptc_now
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gpio_in <= '0;
         ptc_now <= {32'h5, 30'h0};
      end
      else
      begin
         gpio_in <= level_req;
         ptc_now.nanoseconds <= ptc_now.nanoseconds + 30'ha;
      end
   end
endmodule : pin_source

// ### bench/tb_top.sv
// Self-checking bench for the GPIO timestamp capture block
module tb_top
   import capture_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic [15:0] req = '0, gpio_in;
   ptc_time_t ptc_now, tl, t[8];
   int errors = 0, checks = 0;
   gpio_capture i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .gpio_in, .ptc_now, .irq);
   pin_source i_pins (.pclk, .presetn, .level_req(req), .gpio_in, .ptc_now);
   initial forever #5 pclk = ~pclk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         errors++;
         $display("[FAIL] %s exp %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1)
      begin
         errors++;
         $display("[FAIL] bus answer exp 1 seen %b", pready);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [11:0] sa(int u, int s, int p);
      return 12'h100 + 12'(u * 128 + s * 16 + p * 4);
   endfunction : sa
   // Stored time is the value two edges after the pin moves
   task automatic pin(int p, logic v);
      @(posedge pclk);
      req[p] <= v;
      @(posedge pclk);
      #1 tl = ptc_now;
      tl.nanoseconds += 30'h14;
      repeat (4) @(posedge pclk);
      #1;
   endtask : pin
   task automatic cs(int u, int s, ptc_time_t x);
      apb(0, sa(u, s, 0), '0);
      chk("seconds", r, x.seconds);
      apb(0, sa(u, s, 1), '0);
      chk("nanoseconds", r, {2'b0, x.nanoseconds});
      apb(0, sa(u, s, 2), '0);
      chk("fraction", 32'(r <= 32'h4), 32'h1);
      chk("fraction ns", 32'(r * FRACTION_STEP_NS <= 32), 32'h1);
   endtask : cs
   task automatic fill(int u, logic [31:0] x);
      apb(0, 12'(64 + 4 * u), '0);
      chk("fill", 32'(r[19:16]), x);
   endtask : fill
   task automatic t_reset;
      apb(0, OFS_ENABLES, '0);
      chk("enables", r, '0);
      apb(0, OFS_CONFIG_BASE, '0);
      chk("config", r, '0);
      apb(0, 12'h00c, '0);
      chk("unmapped", 32'(e), 32'h1);
      apb(0, 12'h10c, '0);
      chk("gap slot", 32'(e), 32'h1);
   endtask : t_reset
   task automatic t_single;
      apb(1, OFS_CONFIG_BASE, 32'h380);
      apb(1, OFS_IRQ_ENABLES, 32'h1);
      apb(1, OFS_ENABLES, 32'h1);
      apb(0, OFS_CONFIG_BASE, '0);
      chk("config back", r, 32'h380);
      pin(3, 1);
      chk("irq set", 32'(irq), 32'h1);
      cs(0, 0, tl);
      pin(3, 0);
      fill(0, 32'h1);
      apb(1, OFS_PENDING, 32'h1);
      @(posedge pclk);
      #1 chk("irq clear", 32'(irq), 32'h0);
      fill(0, 32'h0);
   endtask : t_single
   task automatic t_pulse;
      apb(1, 12'h044, 32'h5c0);
      apb(1, OFS_ENABLES, 32'h3);
      pin(5, 1);
      t[0] = tl;
      pin(5, 0);
      t[1] = tl;
      pin(5, 1);
      cs(1, 0, t[0]);
      cs(1, 1, t[1]);
   endtask : t_pulse
   task automatic t_deep;
      apb(1, 12'h06c, 32'h780);
      apb(1, OFS_ENABLES, 32'h803);
      for (int s = 0; s < 8; s++)
      begin
         pin(7, 1);
         t[s] = tl;
         pin(7, 0);
      end
      fill(11, 32'h8);
      cs(11, 0, t[0]);
      cs(11, 7, t[7]);
   endtask : t_deep
   task automatic t_chain;
      apb(1, 12'h048, 32'h940);
      apb(1, 12'h04c, 32'h1000);
      apb(1, 12'h050, 32'h980);
      apb(1, OFS_ENABLES, 32'h80f);
      for (int s = 0; s < 3; s++)
      begin
         pin(9, 1);
         pin(9, 0);
         t[s] = tl;
      end
      cs(3, 0, t[2]);
      cs(2, 1, t[1]);
      apb(0, OFS_PENDING, '0);
      chk("pending", r, 32'h80e);
      chk("irq masked", 32'(irq), 32'h0);
   endtask : t_chain
   task automatic close_out;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_single;
      t_pulse;
      t_deep;
      t_chain;
      close_out;
   end
   initial
   begin
      #300000;
      errors++;
      close_out;
   end
endmodule : tb_top

// ### include/capture_pkg.sv
// Constants, register map and carrier types for the GPIO timestamp capture block
// Overview of operation
// [R1] Twelve capture units, each on a selectable pin
// [R2] Event latches present precision time value
// [R3] Two samples per unit, held until released
// [R4] Sample has seconds, nanoseconds, fraction index parts
// [R5] Fraction index zero to four, 8ns steps
// [R6] Host adds fraction time to sample time
// [R7] Last unit holds eight samples
// [R8] Chained units take overflow events in order
// [R9] Single edge type fills first sample
// [R10] Both edges: pulse fills first and second
// [R11] Configuration bit 6 enables falling edges
// [R12] Configuration bit 7 enables rising edges
// [R13] Configuration bits 11:8 select the pin
// [R14] Per-unit interrupt enable gates interrupt
// [R15] Unit captures only when its enable set
// [R16] Slower rates derived from one clock
// [R17] Pin and time logic share one clock
// [R18] Per-unit pending flag, software cleared, feeds interrupt
// [R19] Pins synchronised, fixed capture latency
package capture_pkg;
   localparam int NUM_UNITS = 12;
   localparam int DEEP_UNIT = 11;
   localparam int DEPTH_NORMAL = 2;
   localparam int DEPTH_DEEP = 8;
   localparam int NUM_PINS = 16;
   localparam int ADDR_W = 12;

   localparam logic [11:0] OFS_ENABLES = 12'h000;
   localparam logic [11:0] OFS_IRQ_ENABLES = 12'h004;
   localparam logic [11:0] OFS_PENDING = 12'h008;
   localparam logic [11:0] OFS_CONFIG_BASE = 12'h040;
   localparam logic [11:0] OFS_CONFIG_END = 12'h070;
   localparam logic [11:0] OFS_SAMPLE_BASE = 12'h100;
   localparam logic [11:0] OFS_SAMPLE_END = 12'h700;
   localparam int SAMPLE_UNIT_LSB = 7;
   localparam int SAMPLE_SLOT_LSB = 4;
   localparam int SAMPLE_PART_LSB = 2;
   localparam logic [1:0] PART_SECONDS = 2'h0;
   localparam logic [1:0] PART_NANOSECONDS = 2'h1;
   localparam logic [1:0] PART_FRACTION = 2'h2;

   localparam int CFG_FALL_BIT = 6;
   localparam int CFG_RISE_BIT = 7;
   localparam int CFG_PIN_LSB = 8;
   localparam int CFG_PIN_MSB = 11;
   localparam int CFG_CHAIN_BIT = 12;
   localparam int CFG_FILL_LSB = 16;
   localparam logic [6:0] CONFIG_RESET = 7'h00;
   localparam logic [11:0] UNITS_RESET = 12'h000;

   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_PERIOD_NS = 40;
   localparam int REF_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FRACTION_STEP_NS = 8;
   localparam int FRACTION_MAX = 4;

   typedef struct packed {
      logic [31:0] seconds;
      logic [29:0] nanoseconds;
   } ptc_time_t;

   typedef struct packed {
      logic [31:0] seconds;
      logic [29:0] nanoseconds;
      logic [2:0] fraction;
   } sample_t;

   typedef struct packed {
      logic chain;
      logic rise;
      logic fall;
      logic [3:0] pin;
   } unit_cfg_t;
endpackage : capture_pkg

// ### verilog/gpio_capture.sv
// APB-attached bank of GPIO timestamp capture units
module gpio_capture
   import capture_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_PINS-1:0] gpio_in,
   input wire ptc_time_t ptc_now,
   output logic irq
);
   // Bus decode
   wire access_setup = psel & penable & ~pready;
   wire access_done = psel & penable & pready;
   wire do_write = access_done & pwrite;
   wire [11:0] a = paddr[11:0];
   wire sel_enables = (a == OFS_ENABLES);
   wire sel_irq_en = (a == OFS_IRQ_ENABLES);
   wire sel_pending = (a == OFS_PENDING);
   wire sel_cfg = (a >= OFS_CONFIG_BASE) && (a < OFS_CONFIG_END) && (a[1:0] == 2'b00);
   wire [11:0] cfg_off = a - OFS_CONFIG_BASE;
   wire [3:0] cfg_idx = cfg_off[5:2];
   wire in_samples = (a >= OFS_SAMPLE_BASE) && (a < OFS_SAMPLE_END) && (a[1:0] == 2'b00);
   wire [11:0] smp_off = a - OFS_SAMPLE_BASE;
   wire [3:0] smp_unit = smp_off[SAMPLE_UNIT_LSB+3:SAMPLE_UNIT_LSB];
   wire [2:0] smp_slot = smp_off[SAMPLE_SLOT_LSB+2:SAMPLE_SLOT_LSB];
   wire [1:0] smp_part = smp_off[SAMPLE_PART_LSB+1:SAMPLE_PART_LSB];
   wire smp_slot_ok = (smp_unit == 4'(DEEP_UNIT)) ? 1'b1 : (smp_slot < 3'(DEPTH_NORMAL));
   wire sel_sample = in_samples && (smp_part != 2'h3) && smp_slot_ok;
   wire mapped = sel_enables | sel_irq_en | sel_pending | sel_cfg | sel_sample;

   // Software state
   logic [NUM_UNITS-1:0] unit_enables;
   logic [NUM_UNITS-1:0] irq_enables;
   logic [NUM_UNITS-1:0] pending;
   logic [NUM_UNITS-1:0] captured;
   logic [31:0] cfg_rd [NUM_UNITS];
   logic [31:0] unit_rd [NUM_UNITS];

   // Writing one to a pending bit clears it and releases that unit's samples
   wire [NUM_UNITS-1:0] release_req = (do_write && sel_pending) ?
                                      pwdata[NUM_UNITS-1:0] : '0;
   // Set wins over clear when a capture lands on the clearing cycle
   wire [NUM_UNITS-1:0] next_pending = (pending & ~release_req) | captured; // [R18]
   wire next_irq = |(next_pending & irq_enables); // [R14] [R18]

   // Reference divider: one pulse each 40 ns reference period and the phase
   // within it, giving the 8 ns fraction index of the event
   logic [1:0] ref_phase;
   wire ref_wrap = (ref_phase == 2'(REF_CYCLES - 1));
   wire [5:0] phase_ns = 6'(ref_phase * CLK_PERIOD_NS);
   wire [2:0] next_fraction = phase_ns[5:3]; // [R5] [R16]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_phase <= 2'h0;
      end
      else
      begin
         ref_phase <= ref_wrap ? 2'h0 : ref_phase + 2'h1; // [R16] [R17]
      end
   end

   // Time stamp as seen in the detection cycle
   sample_t now_sample;
   assign now_sample = '{seconds: ptc_now.seconds, nanoseconds: ptc_now.nanoseconds,
                         fraction: next_fraction}; // [R2] [R4]

   // Pin synchroniser; stage one feeds only stage two
   logic [NUM_PINS-1:0] pin_meta;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] pin_prev;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end
      else
      begin
         pin_meta <= gpio_in; // [R19]
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   wire [NUM_PINS-1:0] pin_rise = pin_sync & ~pin_prev; // [R19]
   wire [NUM_PINS-1:0] pin_fall = ~pin_sync & pin_prev;

   // Overflow carried to the next unit in the chain, registered to break the ring
   logic [NUM_UNITS-1:0] carry_valid;
   sample_t carry_sample [NUM_UNITS];

   genvar u;
   generate
      for (u = 0; u < NUM_UNITS; u++)
      begin : g_unit
         localparam int DEPTH = (u == DEEP_UNIT) ? DEPTH_DEEP : DEPTH_NORMAL; // [R3] [R7]
         localparam int PREV = (u == 0) ? NUM_UNITS - 1 : u - 1;
         unit_cfg_t cfg;
         sample_t slots [DEPTH];
         logic [3:0] fill;

         wire cfg_write = do_write && sel_cfg && (cfg_idx == 4'(u));
         wire own_edge = (cfg.rise & pin_rise[cfg.pin]) |
                         (cfg.fall & pin_fall[cfg.pin]); // [R11] [R12] [R13]
         wire own_hit = unit_enables[u] & ~cfg.chain & own_edge; // [R15]
         wire chain_hit = unit_enables[u] & cfg.chain & carry_valid[PREV]; // [R8] [R15]
         wire hit = own_hit | chain_hit;
         sample_t hit_sample;
         assign hit_sample = cfg.chain ? carry_sample[PREV] : now_sample;
         wire [3:0] base = release_req[u] ? 4'h0 : fill;
         wire has_room = (base < 4'(DEPTH));
         // First edge into slot one, the next (other edge of a pulse) into slot two
         wire store = hit & has_room; // [R3] [R9] [R10]
         assign captured[u] = store;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cfg <= CONFIG_RESET;
               fill <= 4'h0;
               carry_valid[u] <= 1'b0;
               carry_sample[u] <= '0;
            end
            else
            begin
               if (cfg_write)
               begin
                  cfg <= '{chain: pwdata[CFG_CHAIN_BIT], rise: pwdata[CFG_RISE_BIT],
                           fall: pwdata[CFG_FALL_BIT],
                           pin: pwdata[CFG_PIN_MSB:CFG_PIN_LSB]};
               end
               fill <= store ? base + 4'h1 : base; // [R3]
               carry_valid[u] <= hit & ~has_room; // [R8]
               carry_sample[u] <= hit_sample;
            end
         end

         // Sample storage needs no reset; fill count says what is valid
         always_ff @(posedge pclk)
         begin
            if (store)
            begin
               slots[base[$clog2(DEPTH)-1:0]] <= hit_sample; // [R2] [R9] [R10]
            end
         end

         // Compare at four bits so that a depth of eight does not wrap to zero
         wire [2:0] rd_slot = ({1'b0, smp_slot} < 4'(DEPTH)) ? smp_slot : 3'h0;
         sample_t rd_sample;
         assign rd_sample = slots[rd_slot[$clog2(DEPTH)-1:0]];
         assign unit_rd[u] = (smp_part == PART_SECONDS) ? rd_sample.seconds :
                             (smp_part == PART_NANOSECONDS) ? {2'b00, rd_sample.nanoseconds} :
                             {29'h0, rd_sample.fraction}; // [R4] [R6]
         assign cfg_rd[u] = {12'h0, fill, 3'h0, cfg.chain, cfg.pin,
                             cfg.rise, cfg.fall, 6'h0};
      end
   endgenerate

   // Read multiplexer
   wire [31:0] rd_data = sel_enables ? {20'h0, unit_enables} :
                         sel_irq_en ? {20'h0, irq_enables} :
                         sel_pending ? {20'h0, pending} :
                         (sel_cfg && cfg_idx < 4'(NUM_UNITS)) ? cfg_rd[cfg_idx] :
                         (sel_sample && smp_unit < 4'(NUM_UNITS)) ? unit_rd[smp_unit] :
                         32'h0000_0000;

   // Control registers and bus answer: one wait state per access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit_enables <= UNITS_RESET;
         irq_enables <= UNITS_RESET;
         pending <= UNITS_RESET;
         irq <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         if (do_write && sel_enables)
         begin
            unit_enables <= pwdata[NUM_UNITS-1:0]; // [R1] [R15]
         end
         if (do_write && sel_irq_en)
         begin
            irq_enables <= pwdata[NUM_UNITS-1:0]; // [R14]
         end
         pending <= next_pending; // [R18]
         irq <= next_irq; // [R14]
         pready <= access_setup;
         if (access_setup)
         begin
            pslverr <= ~mapped;
            prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_data;
         end
         else
         begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule : gpio_capture
